// >>> rtl/ddrwc_defs.vh
// constants for the ddr write port capture block
`ifndef DDRWC_DEFS_VH
`define DDRWC_DEFS_VH
// ----------------------------------------------------------------
// widths
// ----------------------------------------------------------------
`define DDRWC_DATA_W_DEF 36
`define DDRWC_ADDR_W 20
`define DDRWC_NIB_W 4
`define DDRWC_BYTE_W 9
`define DDRWC_MAX_LANES 4
// ----------------------------------------------------------------
// burst and local array
// ----------------------------------------------------------------
`define DDRWC_BEATS 4
`define DDRWC_BEAT_W 2
`define DDRWC_BEAT_LAST 2'h3
`define DDRWC_MEM_ABITS 4
`define DDRWC_MEM_IW 6
// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define DDRWC_BEAT_RST 2'h0
`define DDRWC_SYNC_RST 1'b0
// ----------------------------------------------------------------
// state codes, one-hot
// ----------------------------------------------------------------
`define DDRWC_ST_IDLE 2'h1
`define DDRWC_ST_BURST 2'h2
`endif

// >>> rtl/ddrwc_mem.v
// local storage array with per-lane write enables
`timescale 1ns/100ps
`include "ddrwc_defs.vh"
module ddrwc_mem #(
  parameter DATA_W = 36,
  parameter LANES = 4,
  parameter LANE_W = 9
) (
  input wire mclk_i,
  input wire ce_i,
  input wire wr_i,
  input wire [`DDRWC_MEM_IW-1:0] wr_idx_i,
  input wire [DATA_W-1:0] wr_data_i,
  input wire [LANES-1:0] wr_lane_en_i,
  input wire [`DDRWC_MEM_IW-1:0] rd_idx_i,
  output wire [DATA_W-1:0] rd_data_o
);
  // ----------------------------------------------------------------
  // storage, one word per address and beat, split into lanes
  // ----------------------------------------------------------------
  genvar g;
  // each lane owns its own array so every bit has a single writer
  generate
    for (g = 0; g < LANES; g = g + 1) begin : g_lane
      reg [LANE_W-1:0] lane_mem_r [0:(1<<`DDRWC_MEM_IW)-1]; // this lane of every word
      reg [LANE_W-1:0] lane_rd_r; // registered read of this lane
      // lane write, a disabled lane keeps its old bits
      always @(posedge mclk_i) begin
        if (ce_i && wr_i && wr_lane_en_i[g]) begin
          lane_mem_r[wr_idx_i] <= wr_data_i[g*LANE_W +: LANE_W];
        end
      end
      // registered read port of this lane
      always @(posedge mclk_i) begin
        if (ce_i) begin
          lane_rd_r <= lane_mem_r[rd_idx_i];
        end
      end
      assign rd_data_o[g*LANE_W +: LANE_W] = lane_rd_r;
    end
  endgenerate
endmodule

// >>> rtl/ddrwc_top.v
// write port capture of a double data rate synchronous sram
// Operation
// - capture data on both input clock rises
// - sample select on positive clock rise
// - deselected port ignores data, array unchanged
// - width 8 uses two nibble masks
// - masks sampled on the data edge
// - masked nibble discarded, stored nibble unchanged
// - wider widths use nine-bit lane masks
// - address sampled on positive rise when selected
// - accesses start only on positive clock rise
`timescale 1ns/100ps
`include "ddrwc_defs.vh"
module ddrwc_top #(
  parameter DATA_W = `DDRWC_DATA_W_DEF
) (
  input wire mclk_i,
  input wire rst_i,
  input wire ce_i,
  input wire k_pin_i,
  input wire k_n_pin_i,
  input wire write_port_select_n_i,
  input wire [`DDRWC_ADDR_W-1:0] addr_i,
  input wire [DATA_W-1:0] wr_data_i,
  input wire low_nibble_mask_n_i,
  input wire high_nibble_mask_n_i,
  input wire [`DDRWC_MAX_LANES-1:0] lane_write_mask_n_i,
  input wire [`DDRWC_MEM_IW-1:0] rd_idx_i,
  output reg wr_valid_o,
  output reg [`DDRWC_ADDR_W-1:0] wr_addr_o,
  output reg [`DDRWC_BEAT_W-1:0] wr_beat_o,
  output reg [DATA_W-1:0] wr_data_o,
  output reg [`DDRWC_MAX_LANES-1:0] wr_lane_en_o,
  output reg busy_o,
  output wire [DATA_W-1:0] rd_data_o
);
  // ----------------------------------------------------------------
  // lane geometry
  // ----------------------------------------------------------------
  localparam NIBBLE_MODE = (DATA_W == 8);
  localparam LANE_W = NIBBLE_MODE ? `DDRWC_NIB_W : `DDRWC_BYTE_W;
  localparam LANES = DATA_W / LANE_W;
  localparam PIN_W = 3 + `DDRWC_ADDR_W + DATA_W + LANES; // synced pin bundle
  localparam ST_IDLE = `DDRWC_ST_IDLE; // idle, waiting for select
  localparam ST_BURST = `DDRWC_ST_BURST; // burst in progress

  // ----------------------------------------------------------------
  // mask pins folded into one active-low vector
  // ----------------------------------------------------------------
  wire [LANES-1:0] mask_n_pins; // raw masks, one per lane
  generate
    if (NIBBLE_MODE) begin : g_nib
      assign mask_n_pins = {high_nibble_mask_n_i, low_nibble_mask_n_i};
    end else begin : g_byte
      assign mask_n_pins = lane_write_mask_n_i[LANES-1:0];
    end
  endgenerate

  // ----------------------------------------------------------------
  // two-stage synchronisers, all pins share one depth
  // ----------------------------------------------------------------
  wire [PIN_W-1:0] pins_raw; // pins, bundled
  reg [PIN_W-1:0] sync1_r; // first stage, read only by second
  reg [PIN_W-1:0] sync2_r; // second stage, safe to use
  reg k_last_r; // previous synced positive clock
  reg k_n_last_r; // previous synced negative clock
  assign pins_raw = {k_pin_i, k_n_pin_i, write_port_select_n_i, addr_i, wr_data_i, mask_n_pins};
  // keeping every pin on the same depth keeps data aligned with its clock edge
  always @(posedge mclk_i) begin
    if (rst_i) begin
      sync1_r <= {PIN_W{`DDRWC_SYNC_RST}};
      sync2_r <= {PIN_W{`DDRWC_SYNC_RST}};
      k_last_r <= `DDRWC_SYNC_RST;
      k_n_last_r <= `DDRWC_SYNC_RST;
    end else if (ce_i) begin
      sync1_r <= pins_raw;
      sync2_r <= sync1_r;
      k_last_r <= sync2_r[PIN_W-1];
      k_n_last_r <= sync2_r[PIN_W-2];
    end
  end

  // ----------------------------------------------------------------
  // unpack synced pins
  // ----------------------------------------------------------------
  wire k_s; // positive input clock
  wire k_n_s; // negative input clock
  wire sel_n_s; // write port select, active low
  wire [`DDRWC_ADDR_W-1:0] addr_s; // shared address
  wire [DATA_W-1:0] data_s; // write data
  wire [LANES-1:0] mask_n_s; // lane masks, active low
  assign {k_s, k_n_s, sel_n_s, addr_s, data_s, mask_n_s} = sync2_r;

  // rising edges of each input clock
  wire k_rise = k_s & ~k_last_r;
  wire k_n_rise = k_n_s & ~k_n_last_r;

  // ----------------------------------------------------------------
  // burst state
  // ----------------------------------------------------------------
  reg [1:0] state_r; // one-hot state
  reg [1:0] state_nxt;
  reg [`DDRWC_BEAT_W-1:0] beat_r; // next beat to capture
  reg [`DDRWC_BEAT_W-1:0] beat_nxt;
  reg [`DDRWC_ADDR_W-1:0] addr_r; // burst address
  reg [`DDRWC_ADDR_W-1:0] addr_nxt;
  reg cap; // capture a word this cycle
  reg [`DDRWC_BEAT_W-1:0] cap_beat; // beat of captured word
  reg [`DDRWC_ADDR_W-1:0] cap_addr; // address of captured word

  // even beats ride the positive clock, odd beats the negative one
  wire beat_odd = beat_r[0];
  wire beat_edge = beat_odd ? k_n_rise : k_rise;

  // next state and capture decisions
  always @* begin
    state_nxt = state_r;
    beat_nxt = beat_r;
    addr_nxt = addr_r;
    cap = 1'b0;
    cap_beat = beat_r;
    cap_addr = addr_r;
    case (state_r)
      ST_IDLE: begin
        // a new access only on a positive clock rise with select low
        if (k_rise && !sel_n_s) begin
          state_nxt = ST_BURST;
          addr_nxt = addr_s;
          beat_nxt = `DDRWC_BEAT_RST + 2'h1;
          cap = 1'b1;
          cap_beat = `DDRWC_BEAT_RST;
          cap_addr = addr_s;
        end
        // select high: data and address ignored, nothing written
      end
      ST_BURST: begin
        if (beat_edge) begin
          cap = 1'b1;
          if (beat_r == `DDRWC_BEAT_LAST) begin
            state_nxt = ST_IDLE;
            beat_nxt = `DDRWC_BEAT_RST;
          end else begin
            beat_nxt = beat_r + 2'h1;
          end
        end
      end
      default: begin
        state_nxt = ST_IDLE;
        beat_nxt = `DDRWC_BEAT_RST;
      end
    endcase
  end

  // state registers
  always @(posedge mclk_i) begin
    if (rst_i) begin
      state_r <= ST_IDLE;
      beat_r <= `DDRWC_BEAT_RST;
      addr_r <= {`DDRWC_ADDR_W{1'b0}};
    end else if (ce_i) begin
      state_r <= state_nxt;
      beat_r <= beat_nxt;
      addr_r <= addr_nxt;
    end
  end

  // ----------------------------------------------------------------
  // captured word and lane enables
  // ----------------------------------------------------------------
  wire [LANES-1:0] lane_en; // lanes to write this word
  wire [`DDRWC_MAX_LANES-1:0] lane_en_wide; // lane enables padded to the port width
  genvar g;
  generate
    for (g = 0; g < `DDRWC_MAX_LANES; g = g + 1) begin : g_en
      if (g < LANES) begin : g_used
        // mask sampled with the same edge as its data
        assign lane_en[g] = ~mask_n_s[g];
        assign lane_en_wide[g] = lane_en[g];
      end else begin : g_unused
        // lanes beyond the configured width never write
        assign lane_en_wide[g] = 1'b0;
      end
    end
  endgenerate

  // output word, held until the next capture
  always @(posedge mclk_i) begin
    if (rst_i) begin
      wr_valid_o <= 1'b0;
      wr_addr_o <= {`DDRWC_ADDR_W{1'b0}};
      wr_beat_o <= `DDRWC_BEAT_RST;
      wr_data_o <= {DATA_W{1'b0}};
      wr_lane_en_o <= {`DDRWC_MAX_LANES{1'b0}};
      busy_o <= 1'b0;
    end else if (ce_i) begin
      wr_valid_o <= cap;
      busy_o <= (state_nxt == ST_BURST);
      if (cap) begin
        wr_addr_o <= cap_addr;
        wr_beat_o <= cap_beat;
        wr_data_o <= data_s;
        wr_lane_en_o <= lane_en_wide;
      end
    end
  end

  // ----------------------------------------------------------------
  // local array, written one captured word per cycle
  // ----------------------------------------------------------------
  wire [`DDRWC_MEM_IW-1:0] mem_idx = {cap_addr[`DDRWC_MEM_ABITS-1:0], cap_beat};
  ddrwc_mem #(
    .DATA_W(DATA_W),
    .LANES(LANES),
    .LANE_W(LANE_W)
  ) u_mem (
    .mclk_i(mclk_i),
    .ce_i(ce_i),
    .wr_i(cap),
    .wr_idx_i(mem_idx),
    .wr_data_i(data_s),
    .wr_lane_en_i(lane_en),
    .rd_idx_i(rd_idx_i),
    .rd_data_o(rd_data_o)
  );
endmodule

// >>> dv/ddrwc_assertions.sv
// checker for the write port capture block
`timescale 1ns/100ps
module ddrwc_chk (
  input wire mclk_i,
  input wire rst_i,
  input wire write_port_select_n_i,
  input wire wr_valid_o,
  input wire [19:0] wr_addr_o,
  input wire [1:0] wr_beat_o,
  input wire busy_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  // one pulse per captured word
  AST_PULSE: assert property (wr_valid_o |=> !wr_valid_o)
    else $error("valid pulse too long");
  // a burst opens with beat zero
  AST_START: assert property ($rose(busy_o) |-> wr_valid_o && wr_beat_o == 2'h0)
    else $error("burst opened without beat zero");
  AST_BUSY0: assert property (wr_valid_o && wr_beat_o == 2'h0 |-> busy_o)
    else $error("beat zero without busy");
  AST_END: assert property (wr_valid_o && wr_beat_o == 2'h3 |-> !busy_o)
    else $error("busy after last beat");
  AST_FELL: assert property ($fell(busy_o) |-> wr_valid_o && wr_beat_o == 2'h3)
    else $error("burst closed early");
  AST_BEAT_CHG: assert property ($changed(wr_beat_o) |-> wr_valid_o)
    else $error("beat moved without capture");
  // address is taken once per burst
  AST_ADDR: assert property (wr_valid_o && wr_beat_o != 2'h0 |-> $stable(wr_addr_o))
    else $error("address resampled in burst");
  // a deselected port never opens a burst
  AST_DESEL: assert property ($past(write_port_select_n_i, 2) && $past(write_port_select_n_i, 3)
    && $past(write_port_select_n_i, 4) |-> !(wr_valid_o && wr_beat_o == 2'h0))
    else $error("write while deselected");
endmodule
bind ddrwc_top ddrwc_chk u_chk (.mclk_i(mclk_i), .rst_i(rst_i), .write_port_select_n_i(write_port_select_n_i),
  .wr_valid_o(wr_valid_o), .wr_addr_o(wr_addr_o), .wr_beat_o(wr_beat_o), .busy_o(busy_o));

// >>> dv/ddrwc_ctl_model.sv
// memory controller model driving the write port pins
`timescale 1ns/100ps
module ddrwc_ctl_model (
  input wire mclk_i,
  output logic k_o = 1'b0,
  output logic k_n_o = 1'b1,
  output logic sel_n_o = 1'b1,
  output logic [19:0] addr_o = 20'h0,
  output logic [35:0] data_o = 36'h0,
  output logic [3:0] mask_o = 4'h0
);
  // one transfer edge, held four cycles so the synchroniser sees it
  task beat(input logic kv, input logic sel, input logic [19:0] a, input logic [35:0] d, input logic [3:0] m);
    @(posedge mclk_i);
    #1;
    k_o = kv;
    k_n_o = !kv;
    sel_n_o = sel;
    addr_o = a;
    data_o = d;
    mask_o = m;
    repeat (3) @(posedge mclk_i);
  endtask
  // released lines do not keep their last value
  task idle;
    @(posedge mclk_i);
    #1;
    sel_n_o = 1'b1;
    addr_o = ~addr_o;
    data_o = ~data_o;
    mask_o = ~mask_o;
  endtask
endmodule

// >>> dv/ddrwc_top_tb.sv
// self-checking bench for the write port capture block
`timescale 1ns/100ps
module ddrwc_top_tb;
  logic mclk_i, rst_i = 1'b1, ce_i = 1'b1;
  logic [5:0] rd_idx = 6'h0;
  wire k, kn, sel_n, valid, busy;
  wire [19:0] addr, wr_addr;
  wire [35:0] data, wr_data, rd_data;
  wire [3:0] mask, lane_en;
  wire [1:0] beat;
  wire valid8;
  wire [19:0] wr_addr8;
  wire [1:0] beat8;
  wire [7:0] wr_data8, rd_data8;
  wire [3:0] lane_en8;
  logic [33:0] q8[$]; // expected captures, nibble configuration
  logic [7:0] mem8[64]; // array model, nibble configuration
  logic [61:0] q[$]; // expected captures
  logic [35:0] mem[64]; // array model
  int n_errors = 0, checks_done = 0;
  ddrwc_ctl_model ctl (.mclk_i(mclk_i), .k_o(k), .k_n_o(kn), .sel_n_o(sel_n), .addr_o(addr), .data_o(data),
    .mask_o(mask));
  ddrwc_top #(.DATA_W(36)) dut (.mclk_i(mclk_i), .rst_i(rst_i), .ce_i(ce_i), .k_pin_i(k), .k_n_pin_i(kn),
    .write_port_select_n_i(sel_n), .addr_i(addr), .wr_data_i(data), .low_nibble_mask_n_i(1'b1),
    .high_nibble_mask_n_i(1'b1), .lane_write_mask_n_i(mask), .rd_idx_i(rd_idx), .wr_valid_o(valid),
    .wr_addr_o(wr_addr), .wr_beat_o(beat), .wr_data_o(wr_data), .wr_lane_en_o(lane_en), .busy_o(busy),
    .rd_data_o(rd_data));
  // nibble configuration on the same pins, masks from the two low mask lines
  ddrwc_top #(.DATA_W(8)) dut8 (.mclk_i(mclk_i), .rst_i(rst_i), .ce_i(ce_i), .k_pin_i(k), .k_n_pin_i(kn),
    .write_port_select_n_i(sel_n), .addr_i(addr), .wr_data_i(data[7:0]), .low_nibble_mask_n_i(mask[0]),
    .high_nibble_mask_n_i(mask[1]), .lane_write_mask_n_i(4'h0), .rd_idx_i(rd_idx), .wr_valid_o(valid8),
    .wr_addr_o(wr_addr8), .wr_beat_o(beat8), .wr_data_o(wr_data8), .wr_lane_en_o(lane_en8), .busy_o(),
    .rd_data_o(rd_data8));
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task chk(input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task wrap_up;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // four-beat burst, select and address scrambled after beat zero
  task automatic wburst(input logic [19:0] a, input bit msk);
    logic [35:0] d;
    logic [3:0] m;
    for (int b = 0; b < 4; b++) begin
      d = 36'({$urandom, $urandom});
      m = msk ? 4'($urandom) : 4'h0;
      q.push_back({a, 2'(b), d, ~m});
      for (int g = 0; g < 4; g++) if (!m[g]) mem[{a[3:0], 2'(b)}][9*g+:9] = d[9*g+:9];
      q8.push_back({a, 2'(b), d[7:0], 2'h0, ~m[1:0]});
      for (int g = 0; g < 2; g++) if (!m[g]) mem8[{a[3:0], 2'(b)}][4*g+:4] = d[4*g+:4];
      ctl.beat(!b[0], b == 0 ? 1'b0 : 1'($urandom), b == 0 ? a : 20'($urandom), d, m);
    end
  endtask
  // every capture compared with the model
  always @(negedge mclk_i) begin
    if (valid === 1'b1) begin
      if (q.size() == 0) chk(64'h1, 64'h0);
      else chk({wr_addr, beat, wr_data, lane_en}, q.pop_front());
    end
    if (valid8 === 1'b1) begin
      if (q8.size() == 0) chk(64'h1, 64'h0);
      else chk({wr_addr8, beat8, wr_data8, lane_en8}, q8.pop_front());
    end
  end
  initial begin
    mclk_i = 1'b0;
    forever #20 mclk_i = ~mclk_i;
  end
  initial begin
    #(40 * 5000);
    n_errors++;
    wrap_up;
  end
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    void'($urandom(32'h86aecdf7));
    repeat (12) @(posedge mclk_i);
    #1 rst_i = 1'b0;
    for (int i = 0; i < 16; i++) wburst({16'($urandom), 4'(i)}, 1'b0);
    for (int i = 0; i < 20; i++) wburst(20'($urandom), 1'b1);
    ctl.beat(1'b1, 1'b1, 20'($urandom), 36'($urandom), 4'h0);
    ctl.beat(1'b0, 1'b1, 20'($urandom), 36'($urandom), 4'h0);
    ctl.idle;
    repeat (8) @(posedge mclk_i);
    #1 ce_i = 1'b0;
    repeat (3) @(posedge mclk_i);
    #1 ce_i = 1'b1;
    for (int i = 0; i < 64; i++) begin
      @(posedge mclk_i);
      #1 rd_idx = 6'(i);
      @(posedge mclk_i);
      #1 chk(rd_data, mem[i]);
      chk(rd_data8, mem8[i]);
    end
    chk(q.size(), 0);
    chk(q8.size(), 0);
    wrap_up;
  end
endmodule
